/* File: rtl/rclc_top.sv */
// Radio click light controller: keying counter, hold timer, interlocks and register slave.
//
// Functional notes
// [R1] Count keyings in a five second window.
// [R2] Three, five, seven keyings give low, mid, high.
// [R3] Valid command holds lights on fifteen minutes.
// [R4] At expiry lights go off or preset.
// [R5] New valid command restarts full hold period.
// [R6] No early switch off, except small end identifiers.
// [R7] Outside day mode runway on with others.
// [R8] Approach never on while runway off.
// [R9] Approach and runway intensity change together.
// [R10] Five step: 1 or 2, 3, 5.
// [R11] Photocell systems only energized, intensity external.
// [R12] Non radio circuits stay on when idle.
// [R13] Optional idle runway low, others preselected.
// [R14] Day mode energizes only day useful circuits.
// [R15] Day mode from photocell or switch.
// [R16] Option drops three keying command by day.
// [R17] Manual selection chooses responding circuits.
// [R18] End identifiers off at low commands, on higher; three and five step ones stay on at low, one step ones light at high only.
// [R19] Other counts ignored, outputs and timer unchanged.
// [R20] Window opens at first keying, evaluated at close.
//
// The Avalon-MM register port and the address map were chosen for this implementation.
`timescale 1ns/1ps

module rclc_top #(
   parameter logic [31:0] WINDOW_CYC = rclc_pkg::WINDOW_CYC,
   parameter logic [39:0] HOLD_CYC   = rclc_pkg::HOLD_CYC
) (
   input  wire logic                      sys_clk_i,
   input  wire logic                      reset_i,
   input  wire logic [7:0]                avs_address_i,
   input  wire logic                      avs_read_i,
   input  wire logic                      avs_write_i,
   input  wire logic [31:0]               avs_writedata_i,
   input  wire logic [3:0]                avs_byteenable_i,
   output logic      [31:0]               avs_readdata_o,
   output logic                           avs_waitrequest_o,
   input  wire logic                      key_i,
   input  wire logic                      photo_day_i,
   input  wire logic                      day_switch_i,
   output logic      [rclc_pkg::NC-1:0]   lamp_on_o,
   output logic      [3*rclc_pkg::NC-1:0] lamp_step_o
);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic rclc_pkg::rclc_cmd_t count_cmd(input logic [3:0] cnt);
      rclc_pkg::rclc_cmd_t c;
      c = rclc_pkg::CMD_NONE;
      // [R2] count to command
      case (cnt)
         rclc_pkg::KEYS_LOW:  c = rclc_pkg::CMD_LOW;
         rclc_pkg::KEYS_MID:  c = rclc_pkg::CMD_MID;
         rclc_pkg::KEYS_HIGH: c = rclc_pkg::CMD_HIGH;
         default:             c = rclc_pkg::CMD_NONE;
      endcase
      return c;
   endfunction : count_cmd

   // Returns {on, step} for a circuit with the given step count.
   function automatic logic [3:0] map_step(input logic [1:0] st, input rclc_pkg::rclc_cmd_t cmd,
                                           input logic end_id, input logic low2);
      logic [3:0] m;
      m = 4'h0;
      if (cmd != rclc_pkg::CMD_NONE) begin
         case (st)
            // [R18] end identifiers off low
            rclc_pkg::STEPS_1: begin
               m = {(!end_id || cmd == rclc_pkg::CMD_HIGH), rclc_pkg::STEP_LOW};
            end
            // [R6] small end identifiers may darken
            rclc_pkg::STEPS_2: begin
               if (end_id && cmd == rclc_pkg::CMD_LOW) begin
                  m = 4'h0;
               end else begin
                  m = {1'b1, (cmd == rclc_pkg::CMD_HIGH) ? rclc_pkg::STEP_TWO
                                                        : rclc_pkg::STEP_LOW};
               end
            end
            rclc_pkg::STEPS_3: begin
               m = {1'b1, 1'b0, cmd};
            end
            // [R10] five step mapping
            default: begin
               case (cmd)
                  rclc_pkg::CMD_LOW: begin
                     m = {1'b1, low2 ? rclc_pkg::STEP_TWO : rclc_pkg::STEP_LOW};
                  end
                  rclc_pkg::CMD_MID: begin
                     m = {1'b1, rclc_pkg::STEP_MID5};
                  end
                  default: begin
                     m = {1'b1, rclc_pkg::STEP_TOP5};
                  end
               endcase
            end
         endcase
      end
      return m;
   endfunction : map_step

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] wm);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r & wm;
   endfunction : merge

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   rclc_pkg::rclc_regs_t      state_reg;
   rclc_pkg::rclc_regs_t      state_next;
   logic                      day_w;
   logic                      key_edge;
   wire  [rclc_pkg::NC-1:0]   tgt_on;
   wire  [3*rclc_pkg::NC-1:0] tgt_step;
   logic [3:0]                cnt_now;
   rclc_pkg::rclc_cmd_t       new_cmd;
   logic                      win_close;
   logic                      bus_acc;
   logic                      bus_commit;

   // [R15] day mode source
   assign day_w    = state_reg.ctrl[rclc_pkg::CTRL_DAY_AUTO] ? photo_day_i : day_switch_i;
   assign key_edge = key_i && !state_reg.key_prev;

   // ----------------------------------------------------------------------
   // Per circuit targets
   // ----------------------------------------------------------------------
   for (genvar i = 0; i < rclc_pkg::NC; i++) begin : g_cir
      logic       radio;
      logic       sel;
      logic       dmask;
      logic       idle_en;
      logic       auto_c;
      logic       act;
      logic       idle_ok;
      logic [3:0] m;
      logic [2:0] idle_step;
      logic       on_c;
      logic [2:0] step_c;
      assign radio     = state_reg.mask[rclc_pkg::MASK_RADIO + i];
      assign sel       = state_reg.mask[rclc_pkg::MASK_SEL + i];
      assign dmask     = state_reg.mask[rclc_pkg::MASK_DAY + i];
      assign idle_en   = state_reg.mask[rclc_pkg::MASK_IDLE + i] || (i == rclc_pkg::CIR_RWY);
      assign auto_c    = state_reg.steps[rclc_pkg::STEPS_AUTO + i];
      assign idle_step = (i == rclc_pkg::CIR_RWY) ? rclc_pkg::STEP_LOW
                       : state_reg.ctrl[rclc_pkg::CTRL_IDLE_STEP +: 3];
      // [R9] one command sets every radio circuit
      assign m         = map_step(state_reg.steps[2*i +: 2], state_reg.cmd,
                                  i == rclc_pkg::CIR_END_ID, state_reg.ctrl[rclc_pkg::CTRL_LOW2]);
      // [R14] [R17] selection and day subset
      assign act       = state_reg.state == rclc_pkg::ST_HOLD && sel && (!day_w || dmask);
      // [R13] idle runway low, others preselected
      assign idle_ok   = state_reg.ctrl[rclc_pkg::CTRL_IDLE_RWY] && !day_w && idle_en;
      always_comb begin
         // [R12] non radio circuits stay on
         if (!radio) begin
            on_c   = 1'b1;
            step_c = auto_c ? 3'h0 : state_reg.ctrl[rclc_pkg::CTRL_IDLE_STEP +: 3];
         end else if (act) begin
            on_c   = m[3];
            // [R11] photocell picks intensity
            step_c = auto_c ? 3'h0 : m[2:0];
         end else if (idle_ok) begin
            // [R4] preset brightness after hold
            on_c   = 1'b1;
            step_c = auto_c ? 3'h0 : idle_step;
         end else begin
            on_c   = 1'b0;
            step_c = 3'h0;
         end
      end
      assign tgt_on[i]          = on_c;
      assign tgt_step[3*i +: 3] = step_c;
   end

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------
   always_comb begin
      state_next          = state_reg;
      state_next.key_prev = key_i;
      bus_acc    = (avs_read_i || avs_write_i) && state_reg.waitreq;
      bus_commit = (avs_read_i || avs_write_i) && !state_reg.waitreq;
      state_next.waitreq = !bus_acc;
      if (bus_acc && avs_read_i) begin
         case (avs_address_i)
            rclc_pkg::REG_CTRL:    state_next.rdata = state_reg.ctrl;
            rclc_pkg::REG_MASK:    state_next.rdata = state_reg.mask;
            rclc_pkg::REG_STEPS:   state_next.rdata = state_reg.steps;
            rclc_pkg::REG_STATUS: begin
               state_next.rdata = {11'h000, state_reg.lamp_on, 4'h0, state_reg.key_cnt,
                                   2'h0, state_reg.win_open, day_w, state_reg.cmd,
                                   state_reg.state};
            end
            rclc_pkg::REG_HOLD_LO: state_next.rdata = state_reg.hold_cnt[31:0];
            rclc_pkg::REG_HOLD_HI: state_next.rdata = {24'h00_0000, state_reg.hold_cnt[39:32]};
            default:               state_next.rdata = 32'h0000_0000;
         endcase
      end
      if (bus_commit && avs_write_i) begin
         case (avs_address_i)
            rclc_pkg::REG_CTRL: begin
               state_next.ctrl = merge(state_reg.ctrl, avs_writedata_i, avs_byteenable_i,
                                       rclc_pkg::CTRL_WMASK);
            end
            rclc_pkg::REG_MASK: begin
               state_next.mask = merge(state_reg.mask, avs_writedata_i, avs_byteenable_i,
                                       rclc_pkg::MASK_WMASK);
            end
            rclc_pkg::REG_STEPS: begin
               state_next.steps = merge(state_reg.steps, avs_writedata_i, avs_byteenable_i,
                                        rclc_pkg::STEPS_WMASK);
            end
            default: begin
               state_next.ctrl = state_reg.ctrl;
            end
         endcase
      end

      cnt_now   = state_reg.key_cnt
                + {3'h0, key_edge && state_reg.key_cnt != rclc_pkg::KEYS_MAX};
      win_close = state_reg.win_open && state_reg.win_cnt == 32'h0000_0000;
      new_cmd   = count_cmd(cnt_now);
      // [R16] three keyings dropped by day
      if (day_w && state_reg.ctrl[rclc_pkg::CTRL_DAY_NO3] && new_cmd == rclc_pkg::CMD_LOW) begin
         new_cmd = rclc_pkg::CMD_NONE;
      end
      // [R20] window opens at first keying
      if (!state_reg.win_open) begin
         if (key_edge) begin
            state_next.win_open = 1'b1;
            state_next.win_cnt  = WINDOW_CYC - 32'h0000_0001;
            state_next.key_cnt  = 4'h1;
         end
      end else if (win_close) begin
         // [R1] count evaluated at close
         state_next.win_open = 1'b0;
         state_next.key_cnt  = 4'h0;
      end else begin
         state_next.win_cnt = state_reg.win_cnt - 32'h0000_0001;
         state_next.key_cnt = cnt_now;
      end

      case (state_reg.state)
         rclc_pkg::ST_IDLE: begin
            // [R3] energize and start hold
            if (win_close && new_cmd != rclc_pkg::CMD_NONE) begin
               state_next.state    = rclc_pkg::ST_HOLD;
               state_next.cmd      = new_cmd;
               state_next.hold_cnt = HOLD_CYC - 40'h00_0000_0001;
            end
         end
         rclc_pkg::ST_HOLD: begin
            // [R5] restart full period
            if (win_close && new_cmd != rclc_pkg::CMD_NONE) begin
               state_next.cmd      = new_cmd;
               state_next.hold_cnt = HOLD_CYC - 40'h00_0000_0001;
            // [R4] expiry ends hold
            end else if (state_reg.hold_cnt == 40'h00_0000_0000) begin
               state_next.state = rclc_pkg::ST_IDLE;
               state_next.cmd   = rclc_pkg::CMD_NONE;
            // [R19] invalid counts leave timer running
            end else begin
               state_next.hold_cnt = state_reg.hold_cnt - 40'h00_0000_0001;
            end
         end
         default: begin
            state_next.state = rclc_pkg::ST_IDLE;
            state_next.cmd   = rclc_pkg::CMD_NONE;
         end
      endcase

      state_next.lamp_on   = tgt_on;
      state_next.lamp_step = tgt_step;
      // [R7] runway follows other circuits
      if (!day_w && |(tgt_on & ~(rclc_pkg::NC'(1) << rclc_pkg::CIR_RWY))
          && !tgt_on[rclc_pkg::CIR_RWY]) begin
         state_next.lamp_on[rclc_pkg::CIR_RWY]           = 1'b1;
         state_next.lamp_step[3*rclc_pkg::CIR_RWY +: 3] = rclc_pkg::STEP_LOW;
      end
      // [R8] approach needs runway
      if (!state_next.lamp_on[rclc_pkg::CIR_RWY]) begin
         state_next.lamp_on[rclc_pkg::CIR_APPR]           = 1'b0;
         state_next.lamp_step[3*rclc_pkg::CIR_APPR +: 3] = 3'h0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (reset_i) begin
         state_reg           <= '0;
         state_reg.state     <= rclc_pkg::ST_IDLE;
         state_reg.cmd       <= rclc_pkg::CMD_NONE;
         state_reg.ctrl      <= rclc_pkg::CTRL_RST;
         state_reg.mask      <= rclc_pkg::MASK_RST;
         state_reg.steps     <= rclc_pkg::STEPS_RST;
         state_reg.waitreq   <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign avs_readdata_o    = state_reg.rdata;
   assign avs_waitrequest_o = state_reg.waitreq;
   assign lamp_on_o         = state_reg.lamp_on;
   assign lamp_step_o       = state_reg.lamp_step;

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_valid_close;
      win_close && new_cmd != rclc_pkg::CMD_NONE;
   endsequence

   sequence s_bad_close;
      win_close && new_cmd == rclc_pkg::CMD_NONE
      && (state_reg.state == rclc_pkg::ST_IDLE || state_reg.hold_cnt != 40'h00_0000_0000);
   endsequence

   AST_WIN_OPEN: assert property (!state_reg.win_open && key_edge |=> // [R20]
      state_reg.win_open && state_reg.key_cnt == 4'h1 && state_reg.win_cnt == WINDOW_CYC - 1)
      else $error("window did not open at first keying");

   AST_WIN_CLOSE: assert property (win_close |=> !state_reg.win_open) // [R1]
      else $error("window did not close");

   AST_CNT_MAP: assert property (win_close && cnt_now == rclc_pkg::KEYS_MID |=> // [R2]
      state_reg.cmd == rclc_pkg::CMD_MID && state_reg.state == rclc_pkg::ST_HOLD)
      else $error("five keyings did not give middle command");

   AST_HOLD_LOAD: assert property (s_valid_close |=> // [R5]
      state_reg.hold_cnt == HOLD_CYC - 1 && state_reg.state == rclc_pkg::ST_HOLD)
      else $error("hold timer not loaded by valid command");

   AST_EXPIRE: assert property (state_reg.state == rclc_pkg::ST_HOLD // [R4]
      && state_reg.hold_cnt == 40'h00_0000_0000 && !win_close |=>
      state_reg.state == rclc_pkg::ST_IDLE ##1 (state_reg.ctrl[rclc_pkg::CTRL_IDLE_RWY]
      || (lamp_on_o & state_reg.mask[rclc_pkg::MASK_RADIO +: rclc_pkg::NC]
      & ~(rclc_pkg::NC'(1) << rclc_pkg::CIR_RWY)) == '0))
      else $error("hold did not expire");

   AST_NO_EARLY_OFF: assert property (state_reg.state == rclc_pkg::ST_HOLD // [R6]
      && state_reg.hold_cnt != 40'h00_0000_0000 |=> state_reg.state == rclc_pkg::ST_HOLD)
      else $error("lights left hold early");

   AST_IGNORE: assert property (s_bad_close |=> $stable(state_reg.cmd)) // [R19]
      else $error("invalid count changed command");

   AST_RWY_WITH_OTHERS: assert property (!day_w && |tgt_on |=> // [R7]
      lamp_on_o[rclc_pkg::CIR_RWY])
      else $error("runway off while another circuit on");

   AST_APPR_NEEDS_RWY: assert property (lamp_on_o[rclc_pkg::CIR_APPR] |-> // [R8]
      lamp_on_o[rclc_pkg::CIR_RWY])
      else $error("approach on with runway off");

   AST_LINKED: assert property (state_reg.state == rclc_pkg::ST_HOLD && !day_w // [R9]
      && &state_reg.mask[rclc_pkg::MASK_RADIO +: 2] && &state_reg.mask[rclc_pkg::MASK_SEL +: 2]
      && state_reg.steps[1:0] == state_reg.steps[3:2]
      && state_reg.steps[rclc_pkg::STEPS_AUTO +: 2] == 2'h0 |=>
      lamp_step_o[2:0] == lamp_step_o[5:3])
      else $error("approach and runway steps differ");

   AST_DAY_NO3: assert property (win_close && cnt_now == rclc_pkg::KEYS_LOW && day_w // [R16]
      && state_reg.ctrl[rclc_pkg::CTRL_DAY_NO3]
      && (state_reg.state == rclc_pkg::ST_IDLE || state_reg.hold_cnt != 40'h00_0000_0000)
      |=> $stable(state_reg.cmd))
      else $error("three keyings acted in day mode");

   AST_BUS_ACK: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o ##1 avs_waitrequest_o)
      else $error("bus answer not one cycle after request");

endmodule : rclc_top

/* File: rtl/rclc_pkg.sv */
// Constants, field layout and state types of the radio click light controller.
package rclc_pkg;

   // ----------------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------------
   localparam longint unsigned CLK_HZ     = 64'd100_000_000;
   localparam longint unsigned WINDOW_S   = 64'd5;
   localparam longint unsigned HOLD_MIN   = 64'd15;
   localparam logic [31:0]     WINDOW_CYC = 32'(WINDOW_S * CLK_HZ);
   localparam logic [39:0]     HOLD_CYC   = 40'(HOLD_MIN * 64'd60 * CLK_HZ);

   // ----------------------------------------------------------------------
   // Keying counts, steps and circuits
   // ----------------------------------------------------------------------
   localparam logic [3:0] KEYS_LOW  = 4'h3;
   localparam logic [3:0] KEYS_MID  = 4'h5;
   localparam logic [3:0] KEYS_HIGH = 4'h7;
   localparam logic [3:0] KEYS_MAX  = 4'hF;
   localparam logic [2:0] STEP_LOW  = 3'h1;
   localparam logic [2:0] STEP_TWO  = 3'h2;
   localparam logic [2:0] STEP_MID5 = 3'h3;
   localparam logic [2:0] STEP_TOP5 = 3'h5;
   localparam logic [1:0] STEPS_1   = 2'h0;
   localparam logic [1:0] STEPS_2   = 2'h1;
   localparam logic [1:0] STEPS_3   = 2'h2;
   localparam logic [1:0] STEPS_5   = 2'h3;
   localparam int NC       = 5;
   localparam int CIR_RWY  = 0;
   localparam int CIR_APPR = 1;
   localparam int CIR_TWY  = 2;
   localparam int CIR_END_ID = 3;
   localparam int CIR_AUTO = 4;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [7:0]  REG_CTRL    = 8'h00;
   localparam logic [7:0]  REG_MASK    = 8'h04;
   localparam logic [7:0]  REG_STEPS   = 8'h08;
   localparam logic [7:0]  REG_STATUS  = 8'h0C;
   localparam logic [7:0]  REG_HOLD_LO = 8'h10;
   localparam logic [7:0]  REG_HOLD_HI = 8'h14;
   localparam int CTRL_DAY_AUTO  = 0;
   localparam int CTRL_DAY_NO3   = 1;
   localparam int CTRL_LOW2      = 2;
   localparam int CTRL_IDLE_RWY  = 3;
   localparam int CTRL_IDLE_STEP = 4;
   localparam int MASK_RADIO     = 0;
   localparam int MASK_DAY       = 8;
   localparam int MASK_SEL       = 16;
   localparam int MASK_IDLE      = 24;
   localparam int STEPS_AUTO     = 16;
   localparam logic [31:0] CTRL_RST    = 32'h0000_0010;
   localparam logic [31:0] MASK_RST    = 32'h001F_181F;
   localparam logic [31:0] STEPS_RST   = 32'h0010_00AF;
   localparam logic [31:0] CTRL_WMASK  = 32'h0000_007F;
   localparam logic [31:0] MASK_WMASK  = 32'h1F1F_1F1F;
   localparam logic [31:0] STEPS_WMASK = 32'h001F_03FF;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      CMD_NONE = 2'h0,
      CMD_LOW  = 2'h1,
      CMD_MID  = 2'h2,
      CMD_HIGH = 2'h3
   } rclc_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_HOLD = 2'b10
   } rclc_state_t;

   typedef struct packed {
      rclc_state_t       state;
      logic              key_prev;
      logic              win_open;
      logic [31:0]       win_cnt;
      logic [3:0]        key_cnt;
      rclc_cmd_t         cmd;
      logic [39:0]       hold_cnt;
      logic [31:0]       ctrl;
      logic [31:0]       mask;
      logic [31:0]       steps;
      logic              waitreq;
      logic [31:0]       rdata;
      logic [NC-1:0]     lamp_on;
      logic [3*NC-1:0]   lamp_step;
   } rclc_regs_t;

endpackage : rclc_pkg

/* File: test/rclc_radio_model.sv */
// Keying source standing in for the transmitter heard by the receiver.
`timescale 1ns/1ps
module rclc_radio_model (
   input  wire logic sys_clk_i,
   output logic      key_o
);
   initial key_o = 1'b0;
   // Sends n keyings; carrier held and dropped for gap cycles each.
   task automatic send(input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         key_o <= 1'b1;
         repeat (gap) @(posedge sys_clk_i);
         key_o <= 1'b0;
         repeat (gap) @(posedge sys_clk_i);
      end
   endtask : send
endmodule : rclc_radio_model

/* File: test/rclc_top_tb.sv */
// Self-checking bench of the radio click light controller.
`timescale 1ns/1ps
module rclc_top_tb;
   logic        sys_clk_i, reset_i, avs_read_i, avs_write_i;
   logic        key_i, photo_day_i, day_switch_i, avs_waitrequest_o;
   logic [7:0]  avs_address_i;
   logic [31:0] avs_writedata_i, avs_readdata_o, rd;
   logic [4:0]  lamp_on_o;
   logic [14:0] lamp_step_o;
   int          fail_count, comparisons;

   rclc_top #(.WINDOW_CYC(32'h0000_0032), .HOLD_CYC(40'h00_0000_00C8)) dut (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'hF),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .key_i(key_i), .photo_day_i(photo_day_i), .day_switch_i(day_switch_i),
      .lamp_on_o(lamp_on_o), .lamp_step_o(lamp_step_o));
   rclc_radio_model radio (.sys_clk_i(sys_clk_i), .key_o(key_i));

   always #5 sys_clk_i = ~sys_clk_i;

   // ----------------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------------
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : cmp

   // Holds the request until waitrequest is sampled low, then releases it.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      avs_address_i   <= a;
      avs_writedata_i <= d;
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      @(posedge sys_clk_i);
      while (avs_waitrequest_o !== 1'b0) @(posedge sys_clk_i);
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : bus

   task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      cmp(rd, exp);
   endtask : chk_reg

   task automatic chk_lamps(input logic [31:0] exp);
      cmp({12'h000, lamp_on_o, lamp_step_o}, exp);
   endtask : chk_lamps

   task automatic idle(input int c);
      repeat (c) @(posedge sys_clk_i);
   endtask : idle

   // Keys n times, then checks the lamps once the command has landed.
   task automatic click(input int n, input logic [31:0] exp);
      radio.send(n, 3);
      idle(40);
      chk_lamps(exp);
   endtask : click

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // ----------------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      $display("ERROR %0t watchdog expired", $time);
      end_of_test();
   end

   initial begin
      {sys_clk_i, avs_read_i, avs_write_i, photo_day_i, day_switch_i} = '0;
      {fail_count, comparisons} = '0;
      reset_i = 1'b1;
      avs_address_i = 8'h00;
      avs_writedata_i = 32'h0000_0000;
      idle(2);
      reset_i <= 1'b0;
      chk_reg(rclc_pkg::REG_CTRL, rclc_pkg::CTRL_RST);
      chk_reg(rclc_pkg::REG_MASK, rclc_pkg::MASK_RST);
      chk_reg(rclc_pkg::REG_STEPS, rclc_pkg::STEPS_RST);
      chk_reg(rclc_pkg::REG_STATUS, 32'h0000_0001);
      chk_reg(8'h20, 32'h0000_0000);
      chk_reg(rclc_pkg::REG_HOLD_HI, 32'h0000_0000);
      bus(1'b1, rclc_pkg::REG_CTRL, 32'hFFFF_FFFF);
      chk_reg(rclc_pkg::REG_CTRL, rclc_pkg::CTRL_WMASK);
      bus(1'b1, rclc_pkg::REG_CTRL, rclc_pkg::CTRL_RST);
      $display("test registers done");
      click(5, 32'h000F_849B);
      chk_reg(rclc_pkg::REG_HOLD_LO, 32'h0000_00B4);
      idle(177);
      chk_lamps(32'h000F_849B);
      idle(30);
      chk_lamps(32'h0000_0000);
      $display("test hold done");
      click(3, 32'h000F_8249);
      idle(80);
      click(7, 32'h000F_86ED);
      idle(60);
      chk_lamps(32'h000F_86ED);
      click(4, 32'h000F_86ED);
      idle(80);
      chk_lamps(32'h0000_0000);
      bus(1'b1, rclc_pkg::REG_STEPS, 32'h0010_006F);
      click(7, 32'h000F_84ED);
      click(3, 32'h000B_8049);
      idle(200);
      bus(1'b1, rclc_pkg::REG_STEPS, rclc_pkg::STEPS_RST);
      $display("test restart done");
      day_switch_i <= 1'b1;
      click(5, 32'h000C_0400);
      idle(220);
      bus(1'b1, rclc_pkg::REG_CTRL, 32'h0000_0012);
      click(3, 32'h0000_0000);
      bus(1'b1, rclc_pkg::REG_CTRL, 32'h0000_0011);
      day_switch_i <= 1'b0;
      photo_day_i  <= 1'b1;
      click(5, 32'h000C_0400);
      idle(220);
      $display("test day done");
      photo_day_i <= 1'b0;
      bus(1'b1, rclc_pkg::REG_CTRL, 32'h0000_0014);
      click(3, 32'h000F_8252);
      idle(220);
      bus(1'b1, rclc_pkg::REG_MASK, 32'h0001_181F);
      click(5, 32'h0000_8003);
      idle(220);
      bus(1'b1, rclc_pkg::REG_MASK, rclc_pkg::MASK_RST);
      bus(1'b1, rclc_pkg::REG_CTRL, 32'h0000_0018);
      idle(3);
      chk_lamps(32'h0000_8001);
      bus(1'b1, rclc_pkg::REG_CTRL, 32'h0000_0010);
      bus(1'b1, rclc_pkg::REG_MASK, 32'h001F_181B);
      idle(3);
      chk_lamps(32'h0002_8041);
      $display("test options done");
      end_of_test();
   end
endmodule : rclc_top_tb
